/* File: design/phs_defines.vh */
// Purpose: Shared constants for the bus handshake and parity agent.
// Assumes: Bus signals are synchronous to the agent clock.
// Notes: Bus commands are the low nibble carried on the command lines.
`ifndef PHS_DEFINES_VH
`define PHS_DEFINES_VH

`define PHS_CMD_MEM_RD 4'h6
`define PHS_CMD_MEM_WR 4'h7
`define PHS_DEVSEL_TO 3'h5
`define PHS_ST_OK 2'h0
`define PHS_ST_STOP 2'h1
`define PHS_ST_ABORT 2'h2
`define PHS_LINE_IDLE 1'b1

`endif

/* File: design/phs_buf2.v */
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: Single clock, asynchronous active-low reset.
// Notes: o_room_next tells the writer whether a slot is free next cycle.
`timescale 1ns/100ps
`default_nettype none
module phs_buf2 #(
	parameter W = 68
) (
	input wire i_clk,
	input wire i_nrst,
	input wire [W-1:0] i_in_data,
	input wire i_in_valid,
	output reg o_in_ready,
	output wire o_room_next,
	output reg [W-1:0] o_out_data,
	output reg o_out_valid,
	input wire i_out_ready
);
	reg [W-1:0] slot1_q;
	reg [1:0] count_q;
	reg [1:0] count_d;
	wire push = i_in_valid && o_in_ready;
	wire pop = o_out_valid && i_out_ready;

	always @* begin
		count_d = count_q;
		if (push && !pop)
			count_d = count_q + 2'h1;
		else if (pop && !push)
			count_d = count_q - 2'h1;
	end

	assign o_room_next = (count_d != 2'h2);

	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			count_q <= 2'h0;
			slot1_q <= {W{1'b0}};
			o_out_data <= {W{1'b0}};
			o_out_valid <= 1'b0;
			o_in_ready <= 1'b0;
		end else begin
			count_q <= count_d;
			o_out_valid <= (count_d != 2'h0);
			o_in_ready <= (count_d != 2'h2);
			if (pop) begin
				if (count_q == 2'h2)
					o_out_data <= slot1_q;
				else if (push)
					o_out_data <= i_in_data;
			end else if (push) begin
				if (count_q == 2'h0)
					o_out_data <= i_in_data;
				else
					slot1_q <= i_in_data;
			end
		end
	end
endmodule
`default_nettype wire

/* File: design/phs_agent.v */
// Purpose: Bus-side handshake, parity and error signalling of a bus agent.
// Assumes: Bus signals share i_clk; each pin but PERR, SERR and INTA is split into in, out and enable.
// Notes: Open-drain lines only have an enable; the pin is low while it is high.
`timescale 1ns/100ps
`default_nettype none
`include "phs_defines.vh"
module phs_agent #(
	parameter [31:0] BAR_BASE = 32'h80000000,
	parameter [31:0] BAR_MASK = 32'hFFFF0000
) (
	input wire i_clk,
	input wire i_nrst,
	input wire [31:0] i_ad,
	input wire [3:0] i_cbe,
	input wire i_par,
	input wire i_frame_n,
	input wire i_irdy_n,
	input wire i_trdy_n,
	input wire i_devsel_n,
	input wire i_stop_n,
	output reg [31:0] o_ad,
	output reg o_ad_oe,
	output reg [3:0] o_cbe,
	output reg o_cbe_oe,
	output reg o_par,
	output reg o_par_oe,
	output reg o_frame_n,
	output reg o_frame_oe,
	output reg o_irdy_n,
	output reg o_irdy_oe,
	output reg o_trdy_n,
	output reg o_trdy_oe,
	output reg o_devsel_n,
	output reg o_devsel_oe,
	output reg o_stop_n,
	output reg o_stop_oe,
	output reg o_perr_n,
	output reg o_perr_oe,
	output reg o_serr_oe,
	output reg o_inta_oe,
	input wire i_irq,
	output wire [31:0] o_wr_addr,
	output wire [31:0] o_wr_data,
	output wire [3:0] o_wr_be,
	output wire o_wr_valid,
	input wire i_wr_ready,
	output reg [31:0] o_rd_addr,
	output reg o_rd_req,
	input wire [31:0] i_rd_data,
	input wire i_rd_valid,
	output reg o_rd_ack,
	input wire i_tgt_disc,
	input wire i_mst_start,
	input wire i_mst_write,
	input wire [31:0] i_mst_addr,
	input wire [31:0] i_mst_wdata,
	input wire [3:0] i_mst_be,
	output reg o_mst_busy,
	output reg o_mst_done,
	output reg [1:0] o_mst_status,
	output reg [31:0] o_mst_rdata
);
	localparam T_IDLE = 2'h0;
	localparam T_DATA = 2'h1;
	localparam T_TURN = 2'h2;
	localparam M_IDLE = 2'h0;
	localparam M_ADDR = 2'h1;
	localparam M_DATA = 2'h2;
	localparam M_TURN = 2'h3;

	function par_of;
		input [31:0] ad;
		input [3:0] cbe;
		begin
			par_of = ^{ad, cbe};
		end
	endfunction

	reg [1:0] tst_q;
	reg [1:0] mst_q;
	reg t_wr_q;
	reg m_wr_q;
	reg [31:0] t_addr_q;
	reg [2:0] mto_q;
	reg frame_prev_q;
	reg chk_a_q;
	reg chk_d_q;
	reg cap_par_q;
	reg [3:0] m_be_q;
	reg [31:0] m_wdata_q;

	// The bus is sampled on the rising edge, so no synchroniser is needed.
	wire addr_phase = !i_frame_n && frame_prev_q;
	wire cmd_ok = (i_cbe == `PHS_CMD_MEM_RD) || (i_cbe == `PHS_CMD_MEM_WR);
	wire hit = ((i_ad & BAR_MASK) == BAR_BASE) && cmd_ok && (mst_q == M_IDLE);
	wire t_cmp = (tst_q == T_DATA) && !i_irdy_n && !o_trdy_n;
	wire t_end = (tst_q == T_DATA) && i_frame_n && (i_irdy_n || !o_trdy_n || !o_stop_n);
	wire t_push = t_cmp && t_wr_q;
	wire m_cmp = (mst_q == M_DATA) && !o_irdy_n && !i_trdy_n;
	wire m_stop = (mst_q == M_DATA) && !i_stop_n;
	wire m_abort = (mst_q == M_DATA) && i_devsel_n && (mto_q == `PHS_DEVSEL_TO);
	wire m_end = m_cmp || m_stop || m_abort;
	wire m_start = i_mst_start && (mst_q == M_IDLE) && (tst_q == T_IDLE) && i_frame_n && i_irdy_n;
	wire room_next;
	wire par_err = cap_par_q ^ i_par;
	wire [31:0] bus_ad = o_ad_oe ? o_ad : i_ad;
	wire [3:0] bus_cbe = o_cbe_oe ? o_cbe : i_cbe;

	// Two slots let two words complete while the consumer is stalled, so
	// target ready is withdrawn before anything could be lost.
	phs_buf2 #(
		.W(68)
	) u_wbuf (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.i_in_data({t_addr_q, i_cbe, i_ad}),
		.i_in_valid(t_push),
		.o_in_ready(),
		.o_room_next(room_next),
		.o_out_data({o_wr_addr, o_wr_be, o_wr_data}),
		.o_out_valid(o_wr_valid),
		.i_out_ready(i_wr_ready)
	);

	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			frame_prev_q <= `PHS_LINE_IDLE;
			chk_a_q <= 1'b0;
			chk_d_q <= 1'b0;
			cap_par_q <= 1'b0;
			o_par <= 1'b0;
			o_par_oe <= 1'b0;
			o_perr_n <= `PHS_LINE_IDLE;
			o_perr_oe <= 1'b0;
			o_serr_oe <= 1'b0;
			o_inta_oe <= 1'b0;
		end else begin
			frame_prev_q <= i_frame_n;
			o_par <= par_of(bus_ad, bus_cbe);
			o_par_oe <= o_ad_oe;
			cap_par_q <= par_of(i_ad, i_cbe);
			chk_a_q <= addr_phase;
			chk_d_q <= t_push || (m_cmp && !m_wr_q);
			o_serr_oe <= chk_a_q && par_err;
			if (chk_d_q && par_err) begin
				o_perr_n <= 1'b0;
				o_perr_oe <= 1'b1;
			end else if (!o_perr_n) begin
				o_perr_n <= 1'b1;
			end else begin
				o_perr_oe <= 1'b0;
			end
			o_inta_oe <= i_irq;
		end
	end

	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			tst_q <= T_IDLE;
			mst_q <= M_IDLE;
			t_wr_q <= 1'b0;
			m_wr_q <= 1'b0;
			t_addr_q <= 32'h00000000;
			mto_q <= 3'h0;
			m_be_q <= 4'h0;
			m_wdata_q <= 32'h00000000;
			o_ad <= 32'h00000000;
			o_ad_oe <= 1'b0;
			o_cbe <= 4'h0;
			o_cbe_oe <= 1'b0;
			o_frame_n <= `PHS_LINE_IDLE;
			o_frame_oe <= 1'b0;
			o_irdy_n <= `PHS_LINE_IDLE;
			o_irdy_oe <= 1'b0;
			o_trdy_n <= `PHS_LINE_IDLE;
			o_trdy_oe <= 1'b0;
			o_devsel_n <= `PHS_LINE_IDLE;
			o_devsel_oe <= 1'b0;
			o_stop_n <= `PHS_LINE_IDLE;
			o_stop_oe <= 1'b0;
			o_rd_addr <= 32'h00000000;
			o_rd_req <= 1'b0;
			o_rd_ack <= 1'b0;
			o_mst_busy <= 1'b0;
			o_mst_done <= 1'b0;
			o_mst_status <= `PHS_ST_OK;
			o_mst_rdata <= 32'h00000000;
		end else begin
			o_rd_ack <= 1'b0;
			o_mst_done <= 1'b0;
			case (tst_q)
			T_IDLE: begin
				if (addr_phase && hit) begin
					tst_q <= T_DATA;
					t_wr_q <= i_cbe[0];
					t_addr_q <= i_ad;
					o_rd_addr <= i_ad;
					o_rd_req <= !i_cbe[0];
					o_devsel_n <= 1'b0;
					o_devsel_oe <= 1'b1;
					o_trdy_oe <= 1'b1;
					o_stop_oe <= 1'b1;
					o_trdy_n <= !(i_cbe[0] && room_next);
					o_stop_n <= !i_tgt_disc;
				end
			end
			T_DATA: begin
				if (t_end) begin
					tst_q <= T_TURN;
					o_devsel_n <= 1'b1;
					o_trdy_n <= 1'b1;
					o_stop_n <= 1'b1;
					o_ad_oe <= 1'b0;
					o_rd_req <= 1'b0;
					o_rd_ack <= t_cmp && !t_wr_q;
				end else begin
					if (i_tgt_disc)
						o_stop_n <= 1'b0;
					if (t_cmp)
						t_addr_q <= t_addr_q + 32'h00000004;
					if (t_wr_q) begin
						o_trdy_n <= !room_next;
					end else begin
						// Turnaround: the data lines are taken only after the
						// address phase has been released by the master.
						o_ad_oe <= 1'b1;
						if (t_cmp) begin
							o_trdy_n <= 1'b1;
							o_rd_ack <= 1'b1;
							o_rd_req <= 1'b1;
							o_rd_addr <= o_rd_addr + 32'h00000004;
						end else if (o_trdy_n && i_rd_valid && !o_rd_ack) begin
							o_ad <= i_rd_data;
							o_trdy_n <= 1'b0;
							o_rd_req <= 1'b0;
						end
					end
				end
			end
			T_TURN: begin
				tst_q <= T_IDLE;
				o_devsel_oe <= 1'b0;
				o_trdy_oe <= 1'b0;
				o_stop_oe <= 1'b0;
			end
			default: tst_q <= T_IDLE;
			endcase

			case (mst_q)
			M_IDLE: begin
				if (m_start) begin
					mst_q <= M_ADDR;
					m_wr_q <= i_mst_write;
					m_be_q <= i_mst_be;
					m_wdata_q <= i_mst_wdata;
					o_mst_busy <= 1'b1;
					o_ad <= i_mst_addr;
					o_cbe <= i_mst_write ? `PHS_CMD_MEM_WR : `PHS_CMD_MEM_RD;
					o_ad_oe <= 1'b1;
					o_cbe_oe <= 1'b1;
					o_frame_n <= 1'b0;
					o_frame_oe <= 1'b1;
					o_irdy_n <= 1'b1;
					o_irdy_oe <= 1'b1;
				end
			end
			M_ADDR: begin
				mst_q <= M_DATA;
				mto_q <= 3'h0;
				// Single data phase, so frame drops together with initiator ready.
				o_frame_n <= 1'b1;
				o_irdy_n <= 1'b0;
				o_cbe <= m_be_q;
				o_ad <= m_wdata_q;
				o_ad_oe <= m_wr_q;
			end
			M_DATA: begin
				// Without completion every driven value simply holds.
				if (mto_q != `PHS_DEVSEL_TO)
					mto_q <= mto_q + 3'h1;
				if (m_end) begin
					mst_q <= M_TURN;
					o_irdy_n <= 1'b1;
					o_ad_oe <= 1'b0;
					o_cbe_oe <= 1'b0;
					o_frame_oe <= 1'b0;
					o_mst_done <= 1'b1;
					o_mst_busy <= 1'b0;
					if (m_cmp && !m_wr_q)
						o_mst_rdata <= i_ad;
					if (m_cmp)
						o_mst_status <= `PHS_ST_OK;
					else if (m_stop)
						o_mst_status <= `PHS_ST_STOP;
					else
						o_mst_status <= `PHS_ST_ABORT;
				end
			end
			M_TURN: begin
				mst_q <= M_IDLE;
				o_irdy_oe <= 1'b0;
			end
			default: mst_q <= M_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

/* File: testbench/phs_agent_monitor.sv */
// Purpose: Port checks for the bus agent.
// Assumes: Default base address and mask of the agent.
// Notes: Bound to every agent instance.
`timescale 1ns/100ps
`default_nettype none
module phs_agent_monitor (
	input wire i_clk, i_nrst, i_par, i_frame_n, i_irdy_n, i_irq,
	input wire [31:0] i_ad,
	input wire [3:0] i_cbe,
	input wire o_ad_oe, o_par, o_par_oe, o_frame_n, o_frame_oe, o_irdy_n, o_irdy_oe, o_trdy_n, o_trdy_oe,
	input wire o_devsel_n, o_perr_n, o_perr_oe, o_serr_oe, o_inta_oe, o_rd_ack, o_mst_done
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	a_par_even: assert property (o_par_oe |-> o_par == ^{$past(i_ad), $past(i_cbe)})
		else $error("parity wrong");
	a_par_lag: assert property (o_par_oe == $past(o_ad_oe))
		else $error("parity enable wrong");
	a_irq_lag: assert property (o_inta_oe == $past(i_irq))
		else $error("interrupt wrong");
	a_devsel_own: assert property ($fell(o_devsel_n) |-> $past(!i_frame_n && i_cbe[3:1] == 3'h3 && i_ad[31:16] == 16'h8000))
		else $error("claim without decode");
	a_rd_done: assert property (!o_trdy_n && o_trdy_oe && o_ad_oe && !i_irdy_n |=> o_rd_ack && o_trdy_n)
		else $error("read completion wrong");
	a_perr_why: assert property (o_perr_oe && !o_perr_n |-> $past(i_par) != ^{$past(i_ad, 2), $past(i_cbe, 2)})
		else $error("data error wrong");
	a_serr_why: assert property (o_serr_oe |-> $past(i_par) != ^{$past(i_ad, 2), $past(i_cbe, 2)} && $past(i_frame_n, 3) && !$past(i_frame_n, 2))
		else $error("address error wrong");
	a_serr_once: assert property (o_serr_oe |=> !o_serr_oe)
		else $error("system error too long");
	a_frame_last: assert property (o_frame_oe && !o_frame_n |=> o_frame_n && o_frame_oe && !o_irdy_n && o_irdy_oe)
		else $error("frame wrong");
	a_mst_free: assert property (o_mst_done |-> !o_frame_oe ##1 !o_irdy_oe)
		else $error("lines not released");
endmodule
bind phs_agent phs_agent_monitor u_mon (.*);
`default_nettype wire

/* File: testbench/phs_bus_host.sv */
// Purpose: Host bridge and second agent on the far side of the bus.
// Assumes: Bus lines resolve here from both parties' enables.
// Notes: Control lines have pull-ups; an undriven AD toggles every clock.
`timescale 1ns/100ps
`default_nettype none
module phs_bus_host (
	input wire i_clk,
	input wire [31:0] o_ad,
	input wire [3:0] o_cbe,
	input wire o_ad_oe, o_cbe_oe, o_par, o_par_oe, o_frame_n, o_frame_oe, o_irdy_n, o_irdy_oe,
	input wire o_trdy_n, o_trdy_oe, o_devsel_n, o_devsel_oe, o_stop_n, o_stop_oe,
	output wire [31:0] i_ad,
	output wire [3:0] i_cbe,
	output wire i_par, i_frame_n, i_irdy_n, i_trdy_n, i_devsel_n, i_stop_n
);
	logic [31:0] h_ad = 0, f = 32'h3C3C5A5A, tdat = 0, tw = 0;
	logic [31:0] wd[$], rq[$];
	logic [3:0] h_cbe = 0;
	logic ha_oe = 0, hm_oe = 0, ht_oe = 0, hp_oe = 0, hp = 0, bad = 0, fq = 1, rd = 0;
	logic h_frame_n = 1, h_irdy_n = 1, h_trdy_n = 1, h_devsel_n = 1, h_stop_n = 1;
	logic [1:0] ts = 0, tm = 0;
	int c = 0, dly = 0, lost = 0;
	assign i_ad = o_ad_oe ? o_ad : ha_oe ? h_ad : f;
	assign i_cbe = o_cbe_oe ? o_cbe : hm_oe ? h_cbe : f[3:0];
	assign i_par = o_par_oe ? o_par : hp_oe ? hp : f[4];
	assign i_frame_n = o_frame_oe ? o_frame_n : hm_oe ? h_frame_n : 1'b1;
	assign i_irdy_n = o_irdy_oe ? o_irdy_n : hm_oe ? h_irdy_n : 1'b1;
	assign i_trdy_n = o_trdy_oe ? o_trdy_n : ht_oe ? h_trdy_n : 1'b1;
	assign i_devsel_n = o_devsel_oe ? o_devsel_n : ht_oe ? h_devsel_n : 1'b1;
	assign i_stop_n = o_stop_oe ? o_stop_n : ht_oe ? h_stop_n : 1'b1;
	// Parity trails our own AD by one clock; the bench may spoil it on purpose.
	always @(posedge i_clk) begin
		f <= ~f;
		hp_oe <= ha_oe;
		hp <= ^{i_ad, i_cbe} ^ bad;
		fq <= i_frame_n;
		case (ts)
		2'h0: if (fq && !i_frame_n && !hm_oe && tm != 2'h2) begin
			ts <= 2'h1;
			ht_oe <= 1;
			h_devsel_n <= 0;
			rd <= i_cbe == 4'h6;
			c <= 0;
		end
		2'h1: begin
			c <= c + 1;
			if (!i_irdy_n && !(i_trdy_n && i_stop_n)) begin
				ts <= 2'h2;
				h_devsel_n <= 1;
				h_trdy_n <= 1;
				h_stop_n <= 1;
				ha_oe <= 0;
				tw <= i_ad;
			end else if (c == dly) begin
				h_trdy_n <= tm == 2'h1;
				h_stop_n <= tm != 2'h1;
				ha_oe <= rd;
				h_ad <= tdat;
			end
		end
		default: begin
			ts <= 2'h0;
			ht_oe <= 0;
		end
		endcase
	end
	// Burst as master; pb 1 spoils address parity, pb 2 data parity.
	task mx(input logic [3:0] cmd, input logic [31:0] a, input int n, input int pb);
		int k;
		int g;
		k = 0;
		g = 0;
		@(posedge i_clk) #1;
		hm_oe = 1;
		ha_oe = 1;
		h_frame_n = 0;
		h_ad = a;
		h_cbe = cmd;
		bad = pb == 1;
		@(posedge i_clk) #1;
		bad = pb == 2;
		h_cbe = 4'h0;
		h_irdy_n = 0;
		ha_oe = cmd == 4'h7;
		while (k < n && g < 16) begin
			h_frame_n = k == n - 1;
			if (ha_oe)
				h_ad = wd[k];
			@(posedge i_clk);
			g++;
			if (!i_irdy_n && !i_trdy_n) begin
				if (!ha_oe)
					rq.push_back(i_ad);
				k++;
			end else if (!i_stop_n)
				k = n;
			#1;
		end
		// A burst that ran out of cycles is counted so that the bench can tell a hang.
		if (k < n)
			lost++;
		bad = 0;
		h_frame_n = 1;
		h_irdy_n = 1;
		ha_oe = 0;
		wd.delete();
		@(posedge i_clk) #1;
		hm_oe = 0;
	endtask
endmodule
`default_nettype wire

/* File: testbench/phs_agent_test.sv */
// Purpose: Self-checking bench for the bus handshake and parity agent.
// Assumes: Default base address; the far side is the bus host model.
// Notes: Expected words sit in bench queues filled from the stimulus.
`timescale 1ns/100ps
`default_nettype none
`include "phs_defines.vh"
module phs_agent_test;
	logic i_clk = 0, i_nrst = 0, i_irq = 0, i_wr_ready = 0, i_rd_valid = 0, i_tgt_disc = 0;
	logic i_mst_start = 0, i_mst_write = 0;
	logic [31:0] i_mst_addr = 0, i_mst_wdata = 0, s = 24, a, v;
	logic [31:0] ea[$], ed[$], rdv[4];
	logic [3:0] i_mst_be = 0;
	wire [31:0] i_ad, o_ad, o_wr_addr, o_wr_data, o_rd_addr, o_mst_rdata, i_rd_data;
	wire [3:0] i_cbe, o_cbe, o_wr_be;
	wire [1:0] o_mst_status;
	wire i_par, i_frame_n, i_irdy_n, i_trdy_n, i_devsel_n, i_stop_n, o_ad_oe, o_cbe_oe, o_par, o_par_oe;
	wire o_frame_n, o_frame_oe, o_irdy_n, o_irdy_oe, o_trdy_n, o_trdy_oe, o_devsel_n, o_devsel_oe, o_stop_n;
	wire o_stop_oe, o_perr_n, o_perr_oe, o_serr_oe, o_inta_oe, o_wr_valid, o_rd_req, o_rd_ack, o_mst_busy, o_mst_done;
	int failures = 0, checks = 0, nperr = 0, nserr = 0, ndev = 0, rdi = 0, g, k;
	phs_agent u_dut (.*);
	phs_bus_host u_host (.*);
	assign i_rd_data = rdv[rdi[1:0]];
	always #20 i_clk = ~i_clk;
	function logic [31:0] xs();
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task close_out();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task step(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	always @(posedge i_clk) begin
		if ((o_wr_valid & i_wr_ready) === 1'b1) begin
			chk("wr addr", o_wr_addr, ea.pop_front());
			chk("wr data", o_wr_data, ed.pop_front());
			chk("wr be", {28'h0, o_wr_be}, 32'h0);
		end
		nperr += (o_perr_oe & ~o_perr_n) === 1'b1;
		nserr += o_serr_oe === 1'b1;
		ndev += i_devsel_n === 1'b0;
		#1;
		rdi += o_rd_ack === 1'b1;
	end
	initial begin
		rdv = '{xs(), xs(), xs(), xs()};
		step(4);
		i_nrst = 1;
		i_rd_valid = 1;
		i_irq = 1;
		step(2);
		chk("irq pin", {31'h0, o_inta_oe}, 32'h1);
		i_irq = 0;
		a = 32'h80000000 | (xs() & 32'h0000FFF0);
		// Three words with the consumer stalled exceed the two-entry buffer, so the third waits for target ready.
		for (k = 0; k < 3; k++) begin
			v = xs();
			u_host.wd.push_back(v);
			ea.push_back(a + 4 * k);
			ed.push_back(v);
		end
		fork
			u_host.mx(`PHS_CMD_MEM_WR, a, 3, 0);
			begin
				step(8);
				i_wr_ready = 1;
			end
		join
		step(4);
		chk("wr left", ea.size(), 0);
		$display("test burst write done");
		// The burst above held the select line for many cycles; count afresh.
		ndev = 0;
		u_host.wd.push_back(a);
		u_host.mx(`PHS_CMD_MEM_WR, 32'h10000000, 1, 1);
		v = xs();
		u_host.wd.push_back(v);
		ea.push_back(a);
		ed.push_back(v);
		u_host.mx(`PHS_CMD_MEM_WR, a, 1, 2);
		step(4);
		chk("devsel", ndev, 1);
		chk("serr", nserr, 1);
		chk("perr", nperr, 1);
		chk("no claim", u_host.lost, 1);
		$display("test parity errors done");
		u_host.mx(`PHS_CMD_MEM_RD, a, 2, 0);
		for (k = 0; k < 2; k++)
			chk("rd data", u_host.rq[k], rdv[k]);
		$display("test burst read done");
		i_tgt_disc = 1;
		u_host.mx(`PHS_CMD_MEM_RD, a, 2, 0);
		i_tgt_disc = 0;
		step(2);
		chk("stop rd", u_host.rq.size(), 2);
		chk("host lost", u_host.lost, 1);
		$display("test target stop done");
		// Host answers ok, stop or nothing, promptly for reads and slowly for writes.
		for (k = 0; k < 6; k++) begin
			u_host.tm = 2'(k % 3);
			u_host.dly = k / 3 * 2;
			u_host.tdat = xs();
			i_mst_addr = xs() & 32'h7FFFFFFC;
			i_mst_wdata = xs();
			i_mst_write = k / 3;
			i_mst_start = 1;
			step(1);
			i_mst_start = 0;
			chk("busy", {31'h0, o_mst_busy}, 32'h1);
			for (g = 0; g < 30 && o_mst_done !== 1'b1; g++)
				step(1);
			if (g == 30) begin
				failures++;
				close_out();
			end
			chk("status", {30'h0, o_mst_status}, 32'(k % 3));
			if (k == 3)
				chk("mst wr", u_host.tw, i_mst_wdata);
			if (k == 0)
				chk("mst rd", o_mst_rdata, u_host.tdat);
			step(2);
		end
		$display("test master done");
		i_irq = 1;
		step(2);
		chk("irq again", {31'h0, o_inta_oe}, 32'h1);
		i_nrst = 0;
		#1 chk("reset float", {31'h0, o_inta_oe | o_ad_oe | o_frame_oe}, 32'h0);
		$display("test reset done");
		close_out();
	end
endmodule
`default_nettype wire
